// ### src/nand_cache_host.sv
// apb-programmed host for cache, two-plane cache and copy-back program
// assumes one flash die on the pins and software that sends one
// flash cycle per write to the issue register
//
// Overview of operation
// - cache program is 80h, five address cycles, page data, then 15h.
// - cache programming pages must all lie in one erase block.
// - address cycles and data must follow every 80h.
// - ready/busy-only host ends final cache page with 10h, not 15h.
// - final 15h needs status bit 5 polled before any other operation; the code also lets FFh through.
// - two-plane load: 80h, address with plane bit low, data, 11h.
// - after dummy busy, 81h with plane bit high, address, data.
// - 15h programs both planes; final pair ends with 10h.
// - between 11h and 81h only 70h, 78h, 75h or FFh allowed.
// - two-plane pages share page address, differ in plane bit.
// - copy-back: 85h with destination, optional 85h data, then 10h.
`timescale 1ns/1ps
`include "nand_host_consts.svh"
`default_nettype none

module nand_cache_host #(
    parameter int DIV = `NH_DIV_DEFAULT,
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash pins
    output nand_host_pkg::nand_pins_t pins,
    input wire logic [7:0] dq_in,
    input wire logic rb_n_pin
);

    logic rb_sync;
    logic [7:0] dq_sync;
    logic eng_busy;
    logic eng_done;
    logic [7:0] rd_byte;
    logic go;
    nand_host_pkg::cyc_req_t req;

    // control and tracking state
    logic rb_only;
    logic last_page;
    logic err;
    logic in_load;
    logic rnd;
    logic [2:0] addr_cnt;
    logic data_seen;
    logic [7:0] load_op;
    logic tp_win;
    logic cache_act;
    logic pend;
    logic stat_mode;
    logic [7:0] row1;
    logic [7:0] row2;
    logic [7:0] row3;
    logic [7:0] p0_page;
    logic [14:0] seq_block;
    logic [7:0] guard;

    sync2 #(.WIDTH(9)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({rb_n_pin, dq_in}),
        .q({rb_sync, dq_sync})
    );

    nand_cycle #(.DIV(DIV)) u_cycle (
        .clk(pclk),
        .rst_n(presetn),
        .go(go),
        .req(req),
        .busy(eng_busy),
        .done(eng_done),
        .rd_byte(rd_byte),
        .pins(pins),
        .dq_in(dq_sync)
    );

    // apb decode
    wire acc = psel & penable & ~pready;
    wire xfer = psel & penable & pready;
    wire sel_ctrl = (paddr == ADDR_W'(`NH_OFF_CTRL));
    wire sel_issue = (paddr == ADDR_W'(`NH_OFF_ISSUE));
    wire sel_stat = (paddr == ADDR_W'(`NH_OFF_STAT));
    wire sel_clr = (paddr == ADDR_W'(`NH_OFF_CLR));
    wire mapped = sel_ctrl | sel_issue | sel_stat | sel_clr;
    wire wr_issue = pwrite & sel_issue & mapped;

    // requested cycle
    wire [1:0] kind_bits = pwdata[`NH_ISS_KIND_HI:`NH_ISS_KIND_LO];
    wire k_cmd = (kind_bits == 2'h0);
    wire k_addr = (kind_bits == 2'h1);
    wire k_wdata = (kind_bits == 2'h2);
    wire [7:0] op = pwdata[7:0];
    wire is_stat = (op == `NH_OP_STAT) | (op == `NH_OP_STAT_MP)
                 | (op == `NH_OP_STAT_75);
    wire is_rst = (op == `NH_OP_RESET);
    wire is_conf = (op == `NH_OP_PROG) | (op == `NH_OP_DUMMY)
                 | (op == `NH_OP_CACHE);
    wire is_rnd = (op == `NH_OP_CBLOAD) & in_load
                & (addr_cnt == `NH_ADDR_CYCLES);

    // ready only counts once the busy pulse has had time to appear
    wire rb_ok = rb_sync & (guard == 8'h00);
    // wait for the end of the dummy busy time before the second plane
    wire hold81 = k_cmd & (op == `NH_OP_LOAD2) & tp_win & ~rb_ok;
    wire stall = acc & wr_issue & (eng_busy | go | hold81);

    // plane and block checks on the stored row address
    wire plane_bit = row2[0];
    wire [14:0] cur_block = {row3, row2[7:1]};
    wire bad81 = (load_op == `NH_OP_LOAD2)
               & (~plane_bit | (row1 != p0_page));
    wire bad11 = (op == `NH_OP_DUMMY) & plane_bit;
    wire bad_blk = cache_act & (load_op != `NH_OP_CBLOAD)
                 & (cur_block != seq_block);
    wire addr_bad = bad81 | bad11 | bad_blk;

    // refusals of a command cycle
    wire r05 = in_load & ~is_rst & ~is_rnd
             & ((addr_cnt != `NH_ADDR_CYCLES)
             | (is_conf & ~data_seen & (load_op != `NH_OP_CBLOAD)));
    wire r16 = tp_win & ~(is_stat | is_rst
             | (op == `NH_OP_LOAD2));
    wire r09 = pend & ~(is_stat | is_rst);
    wire r_conf = is_conf & ~in_load | is_conf & addr_bad;
    wire refuse = k_cmd & (r05 | r16 | r09 | r_conf);
    wire take = xfer & wr_issue & ~refuse;

    // final page goes out as a normal program confirm
    wire to_prog = rb_only & last_page & (op == `NH_OP_CACHE);
    wire [7:0] sent = to_prog ? `NH_OP_PROG : op;
    wire c_prog = take & k_cmd & (sent == `NH_OP_PROG);
    wire c_cache = take & k_cmd & (sent == `NH_OP_CACHE);
    wire c_dummy = take & k_cmd & (sent == `NH_OP_DUMMY);
    wire c_load = take & k_cmd & ~is_rnd
                & ((op == `NH_OP_LOAD) | (op == `NH_OP_LOAD2)
                | (op == `NH_OP_CBLOAD));
    wire c_rst = take & k_cmd & is_rst;
    wire a_take = take & k_addr & in_load;

    wire [31:0] stat_word = {16'h0000, rd_byte, stat_mode, cache_act,
                             in_load, tp_win, pend, err, rb_ok, eng_busy};
    wire [31:0] rd_mux = sel_ctrl ? {30'h0, last_page, rb_only}
                       : sel_stat ? stat_word : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc & ~stall;
            pslverr <= acc & ~stall & ~mapped;
            prdata <= (acc & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // control register and refusal flag; a new refusal beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_only <= 1'(`NH_CTRL_RESET);
            last_page <= 1'b0;
            err <= 1'b0;
        end else begin
            if (xfer & pwrite & sel_ctrl) begin
                rb_only <= pwdata[`NH_CTRL_RB_ONLY];
                last_page <= pwdata[`NH_CTRL_LAST];
            end
            if (xfer & wr_issue & refuse) begin
                err <= 1'b1;
            end else if (xfer & pwrite & sel_clr) begin
                err <= 1'b0;
            end
        end
    end

    // launch the accepted cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go <= 1'b0;
            req <= '{kind: nand_host_pkg::CYC_CMD, value: 8'h00};
        end else begin
            go <= take;
            if (take) begin
                req.kind <= nand_host_pkg::cyc_kind_t'(kind_bits);
                req.value <= k_cmd ? sent : op;
            end
        end
    end

    // busy guard after each confirm or reset before trusting ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            guard <= 8'h00;
        end else if (c_prog | c_cache | c_dummy | c_rst) begin
            guard <= 8'(`NH_WB_CYC + 4 * DIV);
        end else if (guard != 8'h00) begin
            guard <= guard - 8'h01;
        end
    end

    // load tracking: address count, row capture, data seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_load <= 1'b0;
            rnd <= 1'b0;
            addr_cnt <= 3'h0;
            data_seen <= 1'b0;
            load_op <= 8'h00;
            row1 <= 8'h00;
            row2 <= 8'h00;
            row3 <= 8'h00;
        end else if (c_rst | c_prog | c_cache | c_dummy) begin
            in_load <= 1'b0;
            rnd <= 1'b0;
        end else if (c_load) begin
            in_load <= 1'b1;
            rnd <= 1'b0;
            addr_cnt <= 3'h0;
            data_seen <= 1'b0;
            load_op <= op;
        end else if (take & k_cmd & is_rnd) begin
            rnd <= 1'b1;
            addr_cnt <= `NH_RND_START;
        end else if (a_take & (addr_cnt != `NH_ADDR_CYCLES)) begin
            addr_cnt <= addr_cnt + 3'h1;
            if (~rnd & (addr_cnt == 3'h2)) begin
                row1 <= op;
            end
            if (~rnd & (addr_cnt == 3'h3)) begin
                row2 <= op;
            end
            if (~rnd & (addr_cnt == 3'h4)) begin
                row3 <= op;
            end
        end else if (take & k_wdata & in_load) begin
            data_seen <= 1'b1;
        end
    end

    // operation tracking across loads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tp_win <= 1'b0;
            cache_act <= 1'b0;
            pend <= 1'b0;
            stat_mode <= 1'b0;
            p0_page <= 8'h00;
            seq_block <= 15'h0000;
        end else begin
            if (c_rst) begin
                tp_win <= 1'b0;
                cache_act <= 1'b0;
                pend <= 1'b0;
            end
            if (c_dummy) begin
                tp_win <= 1'b1;
                p0_page <= row1;
            end
            if (take & k_cmd & (op == `NH_OP_LOAD2)) begin
                tp_win <= 1'b0;
            end
            if (c_cache) begin
                cache_act <= 1'b1;
                if (~cache_act) begin
                    seq_block <= cur_block;
                end
                if (last_page) begin
                    pend <= 1'b1;
                end
            end
            if (c_prog) begin
                cache_act <= 1'b0;
            end
            if (take & k_cmd) begin
                stat_mode <= is_stat;
            end
            // array done seen in a status byte ends the wait
            if (eng_done & stat_mode & rd_byte[`NH_SB_ARRAY_RDY]
                & (req.kind == nand_host_pkg::CYC_RDATA)) begin
                pend <= 1'b0;
            end
        end
    end

endmodule // nand_cache_host

`default_nettype wire

// ### pkg/nand_host_consts.svh
// constants of the cache and copy-back program host controller
// assumes a 100 MHz pclk and byte-wide flash command/address/data pins
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH

// register byte offsets
`define NH_OFF_CTRL 12'h000
`define NH_OFF_ISSUE 12'h004
`define NH_OFF_STAT 12'h008
`define NH_OFF_CLR 12'h00C

// control fields
`define NH_CTRL_RB_ONLY 0
`define NH_CTRL_LAST 1
`define NH_CTRL_RESET 32'h0000_0000

// issue fields
`define NH_ISS_KIND_HI 9
`define NH_ISS_KIND_LO 8

// status fields
`define NH_ST_BUSY 0
`define NH_ST_RB_OK 1
`define NH_ST_ERR 2
`define NH_ST_PEND 3
`define NH_ST_TPWIN 4
`define NH_ST_LOAD 5
`define NH_ST_CACHE 6
`define NH_ST_STMODE 7

// flash status byte bits
`define NH_SB_ARRAY_RDY 5
`define NH_SB_CACHE_RDY 6

// opcodes
`define NH_OP_LOAD 8'h80
`define NH_OP_LOAD2 8'h81
`define NH_OP_CBLOAD 8'h85
`define NH_OP_PROG 8'h10
`define NH_OP_DUMMY 8'h11
`define NH_OP_CACHE 8'h15
`define NH_OP_CBREAD 8'h35
`define NH_OP_STAT 8'h70
`define NH_OP_STAT_MP 8'h78
`define NH_OP_STAT_75 8'h75
`define NH_OP_RESET 8'hFF

// address cycles per load, address count restart for random input (two column cycles follow)
`define NH_ADDR_CYCLES 3'h5
`define NH_RND_START 3'h3

// timing
`define NH_CLK_NS 10
`define NH_T_WB_NS 100
`define NH_WB_CYC ((`NH_T_WB_NS + `NH_CLK_NS - 1) / `NH_CLK_NS)
`define NH_DIV_DEFAULT 4

`endif

// ### pkg/nand_host_pkg.sv
// types shared by the flash host controller files
// assumes nothing beyond the constants header
package nand_host_pkg;

    typedef enum logic [1:0] {
        CYC_CMD,
        CYC_ADDR,
        CYC_WDATA,
        CYC_RDATA
    } cyc_kind_t;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic [7:0] dq_out;
        logic dq_oe_n;
    } nand_pins_t;

    typedef struct packed {
        cyc_kind_t kind;
        logic [7:0] value;
    } cyc_req_t;

endpackage

// ### src/sync2.sv
// two flip-flop synchroniser for pin inputs
// assumes a single pclk domain
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous input and synchronised output
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule // sync2

`default_nettype wire

// ### src/nand_cycle.sv
// one flash bus cycle: setup, strobe low, hold, each DIV pclk long
// assumes dq_in already synchronised and DIV of at least three
`timescale 1ns/1ps
`include "nand_host_consts.svh"
`default_nettype none

module nand_cycle #(
    parameter int DIV = `NH_DIV_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic go,
    input wire nand_host_pkg::cyc_req_t req,
    output logic busy,
    output logic done,
    output logic [7:0] rd_byte,
    // flash pins
    output nand_host_pkg::nand_pins_t pins,
    input wire logic [7:0] dq_in
);

    typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HOLD} cyc_state_t;
    cyc_state_t state;
    logic [7:0] div_cnt;
    logic is_read;
    wire tick = (div_cnt == 8'(DIV - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
        end else if (go || tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pins <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                      re_n: 1'b1, dq_out: 8'h00, dq_oe_n: 1'b1};
            busy <= 1'b0;
            done <= 1'b0;
            rd_byte <= 8'h00;
            is_read <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (go) begin
                        state <= ST_SETUP;
                        busy <= 1'b1;
                        is_read <= (req.kind == nand_host_pkg::CYC_RDATA);
                        pins.ce_n <= 1'b0;
                        pins.cle <= (req.kind == nand_host_pkg::CYC_CMD);
                        pins.ale <= (req.kind == nand_host_pkg::CYC_ADDR);
                        pins.dq_out <= req.value;
                        // the flash drives dq only during a read
                        pins.dq_oe_n <=
                            (req.kind == nand_host_pkg::CYC_RDATA);
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        state <= ST_LOW;
                        pins.we_n <= is_read;
                        pins.re_n <= !is_read;
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        state <= ST_HOLD;
                        pins.we_n <= 1'b1;
                        pins.re_n <= 1'b1;
                        if (is_read) begin
                            rd_byte <= dq_in;
                        end
                    end
                end
                ST_HOLD: begin
                    if (tick) begin
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                        pins.cle <= 1'b0;
                        pins.ale <= 1'b0;
                        pins.dq_oe_n <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // nand_cycle

`default_nettype wire

// ### verif/nand_cache_host_assertions.sv
// checker of the host's apb answers and flash command pin order
// assumes the package is compiled first; bound into the host below
`timescale 1ns/1ps
`default_nettype none
module nand_cache_host_assertions (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb answer
    input wire logic pready,
    input wire logic pslverr,
    // flash pins
    input wire nand_host_pkg::nand_pins_t pins
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic we_q, open, dseen, win, plane;
    logic [2:0] acnt;
    logic [7:0] kind, pg, pg0;
    // a cycle counts at a selected we_n rise
    wire wev = pins.we_n & ~we_q & ~pins.ce_n;
    wire cmd = wev & pins.cle;
    wire adr = wev & pins.ale;
    wire [7:0] op = pins.dq_out;
    wire conf = cmd & (op == 8'h10 | op == 8'h11 | op == 8'h15);
    wire load = cmd & (op == 8'h80 | op == 8'h81 | op == 8'h85);
    // 85h after a full address: two column bytes follow
    wire rnd = cmd & op == 8'h85 & open & acnt == 3'h5;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            we_q <= 1'b1;
            open <= 1'b0;
            dseen <= 1'b0;
            win <= 1'b0;
            plane <= 1'b0;
            acnt <= 3'h0;
            kind <= 8'h00;
            pg <= 8'h00;
            pg0 <= 8'h00;
        end else begin
            we_q <= pins.we_n;
            if (rnd)
                acnt <= 3'h3;
            else if (load) begin
                open <= 1'b1;
                dseen <= 1'b0;
                acnt <= 3'h0;
                kind <= op;
            end else if (conf | cmd & op == 8'hFF)
                open <= 1'b0;
            if (cmd & op == 8'h11)
                pg0 <= pg;
            if (cmd)
                win <= (win & op != 8'h81 & op != 8'hFF) | op == 8'h11;
            if (adr)
                acnt <= acnt + 3'h1;
            if (adr & acnt == 3'h2)
                pg <= op;
            if (adr & acnt == 3'h3)
                plane <= op[0];
            if (wev & ~pins.cle & ~pins.ale)
                dseen <= 1'b1;
        end
    end
    property p_addr_first;
        cmd & open & acnt != 3'h5 |-> op == 8'hFF;
    endproperty
    a_addr_first: assert property (p_addr_first)
        else $error("cmd in address phase");
    property p_confirm;
        conf |-> open & acnt == 3'h5 & (dseen | kind == 8'h85);
    endproperty
    a_confirm: assert property (p_confirm)
        else $error("confirm without load");
    property p_window;
        cmd & win |-> op inside {8'h70, 8'h78, 8'h75, 8'hFF, 8'h81};
    endproperty
    a_window: assert property (p_window)
        else $error("bad cmd in plane window");
    property p_plane_low;
        cmd & op == 8'h11 |-> !plane;
    endproperty
    a_plane_low: assert property (p_plane_low)
        else $error("first plane bit high");
    property p_plane_high;
        conf & kind == 8'h81 |-> plane;
    endproperty
    a_plane_high: assert property (p_plane_high)
        else $error("second plane bit low");
    property p_same_page;
        conf & kind == 8'h81 |-> pg == pg0;
    endproperty
    a_same_page: assert property (p_same_page)
        else $error("plane pages differ");
    property p_strobe;
        $fell(pins.we_n) |-> !pins.ce_n & pins.re_n ##1
            !pins.we_n & !pins.dq_oe_n;
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("bad write strobe");
    property p_err_ready;
        pslverr |-> pready ##1 !pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("slverr without pready");
endmodule // nand_cache_host_assertions

bind nand_cache_host nand_cache_host_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .pready(pready),
    .pslverr(pslverr), .pins(pins)
);
`default_nettype wire

// ### verif/flash_model.sv
// behavioural flash die: busy times and status byte
// assumes the host's pin struct; every page passes
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
    parameter int T_XFER = 2000,
    parameter int T_PROG = 6000,
    parameter int T_DBSY = 300
) (
    // host pins
    input wire nand_host_pkg::nand_pins_t pins,
    // die outputs
    output logic [7:0] dq_in,
    output logic rb_n_pin
);
    logic cache_rdy = 1'b1;
    logic arr_rdy = 1'b1;
    logic on_arr = 1'b0;
    logic smode = 1'b0;
    logic hold = 1'b0;
    logic [7:0] rdv = 8'h00;
    logic [7:0] op;
    // bit6 cache, bit5 array ready; 1 and 0 pass
    wire [7:0] stat = {1'b1, cache_rdy, arr_rdy, 5'h00};
    assign rb_n_pin = cache_rdy & (arr_rdy | ~on_arr);
    // no pull: released dq shows the inverse
    assign dq_in = hold ? rdv : ~rdv;
    always @(pins.re_n)
        if (pins.re_n === 1'b0) begin
            hold = 1'b1;
            rdv = smode ? stat : 8'h5A;
        end else
            #15 hold = 1'b0;
    task automatic confirm(input logic full);
        #50 cache_rdy = 1'b0;
        on_arr = full;
        wait (arr_rdy);
        #T_XFER arr_rdy = 1'b0;
        cache_rdy = 1'b1;
        #T_PROG arr_rdy = 1'b1;
    endtask
    task automatic pause(input int t);
        #50 cache_rdy = 1'b0;
        #t cache_rdy = 1'b1;
    endtask
    // data bytes are not counted, so partial pages pass
    always @(posedge pins.we_n)
        if (pins.ce_n === 1'b0 && pins.cle === 1'b1) begin
            op = pins.dq_out;
            smode = op inside {8'h70, 8'h78, 8'h75};
            if (op == 8'h10 || op == 8'h15)
                fork
                    confirm(op == 8'h10);
                join_none
            if (op == 8'h11 || op == 8'h35)
                fork
                    pause(op == 8'h11 ? T_DBSY : T_XFER);
                join_none
        end
endmodule // flash_model
`default_nettype wire

// ### verif/nand_cache_host_tb.sv
// self-checking bench: apb master, flash model, random pages
// assumes the checker binds itself into the host
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_consts.svh"
module nand_cache_host_tb;
    localparam logic [11:0] CTL = `NH_OFF_CTRL;
    localparam logic [11:0] ISS = `NH_OFF_ISSUE;
    localparam logic [11:0] ST = `NH_OFF_STAT;
    localparam logic [11:0] CLR = `NH_OFF_CLR;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rb_n_pin;
    logic er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] dq_in, pg, last_cmd;
    nand_host_pkg::nand_pins_t pins;
    int n_mismatch = 0;
    int tests_run = 0;
    time t0;
    nand_cache_host #(.DIV(4), .ADDR_W(12)) uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .dq_in(dq_in), .rb_n_pin(rb_n_pin)
    );
    flash_model fm (.pins(pins), .dq_in(dq_in), .rb_n_pin(rb_n_pin));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // commands that really reached the die
    always @(posedge pins.we_n)
        if (!pins.ce_n && pins.cle)
            last_cmd = pins.dq_out;
    function automatic logic [7:0] f_sb(input logic c, input logic a);
        return {1'b1, c, a, 5'h00};
    endfunction
    task automatic chk(input string s, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fl(input logic [1:0] k, input logic [7:0] b);
        apb(ISS, 1'b1, {22'h0, k, b});
    endtask
    // until idle with status bit b at v
    task automatic poll(input int b, input logic v);
        do apb(ST, 1'b0, 32'h0);
        while (rd[0] !== 1'b0 || rd[b] !== v);
    endtask
    task automatic sread;
        fl(2'h3, 8'h00);
        poll(0, 1'b0);
    endtask
    task automatic load(input logic [7:0] op, input logic [7:0] r2,
                        input logic [7:0] p);
        fl(2'h0, op);
        fl(2'h1, 8'($urandom));
        fl(2'h1, 8'($urandom_range(34, 0)));
        fl(2'h1, p);
        fl(2'h1, r2);
        fl(2'h1, 8'h00);
        repeat ($urandom_range(3, 1)) fl(2'h2, 8'($urandom));
    endtask
    task automatic err_is(input logic e);
        apb(ST, 1'b0, 32'h0);
        chk("error flag", rd[2], e);
        apb(CLR, 1'b1, 32'h0);
    endtask
    initial begin
        #900000;
        n_mismatch++;
        complete_run;
    end
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rd = $urandom(16);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(CTL, 1'b0, 32'h0);
        chk("ctrl reset", rd, `NH_CTRL_RESET);
        apb(12'h010, 1'b0, 32'h0);
        chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
        fl(2'h0, 8'h80);
        fl(2'h0, 8'h15);
        err_is(1'b1);
        fl(2'h0, 8'hFF);
        fl(2'h0, 8'h10);
        poll(1, 1'b1);
        chk("last command", last_cmd, 8'hFF);
        err_is(1'b1);
        // cache pipeline: the second ready waits for the array
        pg = 8'($urandom);
        load(8'h80, 1'b0, pg);
        fl(2'h0, 8'h15);
        poll(1, 1'b1);
        load(8'h80, 1'b0, pg + 8'h1);
        t0 = $time;
        fl(2'h0, 8'h15);
        poll(1, 1'b1);
        chk("pipelined busy", ($time - t0) > 4000, 1'b1);
        chk("cache active", rd[6], 1'b1);
        fl(2'h0, 8'h70);
        sread;
        chk("cache status", rd[15:8], f_sb(1'b1, 1'b0));
        while (rd[13] !== 1'b1) sread;
        chk("array status", rd[15:8], f_sb(1'b1, 1'b1));
        load(8'h80, 8'h02, pg);
        fl(2'h0, 8'h15);
        err_is(1'b1);
        fl(2'h0, 8'hFF);
        apb(CTL, 1'b1, 32'h3);
        load(8'h80, 1'b0, pg + 8'h2);
        fl(2'h0, 8'h15);
        poll(1, 1'b1);
        chk("final confirm", last_cmd, 8'h10);
        apb(CTL, 1'b1, 32'h2);
        load(8'h80, 1'b0, pg + 8'h3);
        fl(2'h0, 8'h15);
        poll(1, 1'b1);
        chk("pending", rd[3], 1'b1);
        fl(2'h0, 8'h80);
        err_is(1'b1);
        fl(2'h0, 8'h70);
        while (rd[13] !== 1'b1) sread;
        apb(ST, 1'b0, 32'h0);
        chk("pend cleared", rd[3], 1'b0);
        apb(CTL, 1'b1, 32'h0);
        // two planes, with a refused command in the window
        pg = 8'($urandom);
        for (int i = 0; i < 2; i++) begin
            load(8'h80, 1'b0, pg + i[7:0]);
            fl(2'h0, 8'h11);
            poll(0, 1'b0);
            chk("plane window", rd[4], 1'b1);
            fl(2'h0, 8'h90);
            err_is(1'b1);
            fl(2'h0, 8'h75);
            load(8'h81, 1'b1, pg + i[7:0]);
            fl(2'h0, i ? 8'h10 : 8'h15);
            poll(1, 1'b1);
            chk("pair confirm", last_cmd, i ? 8'h10 : 8'h15);
        end
        fl(2'h0, 8'h78);
        sread;
        chk("plane status", rd[15:8], f_sb(1'b1, 1'b1));
        for (int i = 0; i < 2; i++) begin
            load(8'h80, i == 0, pg);
            fl(2'h0, 8'h11);
            if (i) begin
                load(8'h81, 1'b1, pg + 8'h5);
                fl(2'h0, 8'h10);
            end
            err_is(1'b1);
            fl(2'h0, 8'hFF);
            poll(1, 1'b1);
        end
        // copy-back with a random input patch
        load(8'h85, 1'b0, pg + 8'h7);
        fl(2'h0, 8'h85);
        fl(2'h1, 8'h00);
        fl(2'h1, 8'h10);
        fl(2'h2, 8'($urandom));
        fl(2'h0, 8'h10);
        poll(1, 1'b1);
        chk("copy back", {rd[2], last_cmd}, 9'h010);
        fl(2'h0, 8'h70);
        repeat (2) begin
            sread;
            chk("copy status", rd[15:8], f_sb(1'b1, 1'b1));
        end
        complete_run;
    end
endmodule // nand_cache_host_tb
`default_nettype wire
